// [common/pmusrb_params.svh]
// pmusrb_params.svh: offsets, field positions, reset values for the pmu serial register bank
// assumes: included by bare name from the package and the design file
`ifndef PMUSRB_PARAMS_SVH
`define PMUSRB_PARAMS_SVH

// register addresses (5-bit serial address space)
`define PMUSRB_ADDR_B3_CODE     5'h00
`define PMUSRB_ADDR_B1_CODE     5'h07
`define PMUSRB_ADDR_B2_CODE     5'h08
`define PMUSRB_ADDR_B3_SLEEP    5'h09
`define PMUSRB_ADDR_REG_CTRL    5'h0A
`define PMUSRB_ADDR_COMP_SETUP  5'h0B
`define PMUSRB_ADDR_INT_MASK    5'h0C
`define PMUSRB_ADDR_INT_FLAGS   5'h0D
`define PMUSRB_ADDR_MISC        5'h0E

// reset values
`define PMUSRB_RST_B3_SEL_HI    7'h64
`define PMUSRB_RST_B3_SEL_LO    7'h3C
`define PMUSRB_RST_B1_CODE      6'h26
`define PMUSRB_RST_B2_SEL_LO    6'h0E
`define PMUSRB_RST_B2_SEL_HI    6'h26
`define PMUSRB_RST_SLP_SEL_HI   7'h53
`define PMUSRB_RST_SLP_SEL_LO   7'h0E
`define PMUSRB_RST_THRESH       6'h19
`define PMUSRB_RST_INT_MASK     5'h01

// regulator control field positions
`define PMUSRB_BIT_B3_ON_STAT   7
`define PMUSRB_BIT_B1_FPWM      4
`define PMUSRB_BIT_B2_FPWM      3
`define PMUSRB_BIT_B3_FPWM      2
`define PMUSRB_BIT_B1_ON        1

// comparator setup field positions
`define PMUSRB_BIT_HYST         7
`define PMUSRB_THRESH_HI        6
`define PMUSRB_THRESH_LO        1
`define PMUSRB_BIT_COMP_ON      0

// misc field positions
`define PMUSRB_BIT_LDO_SLEEP    1
`define PMUSRB_BIT_INT_POL      0

// frame field lengths
`define PMUSRB_CMD_BITS         2
`define PMUSRB_ADDR_BITS        5
`define PMUSRB_DATA_BITS        8
`define PMUSRB_CMD_WRITE        2'h2
`define PMUSRB_CMD_READ         2'h3

`endif

// [common/pmusrb_pkg.sv]
// pmusrb_pkg: types shared by the pmu serial register bank
// assumes: pmusrb_params.svh on the include path
package pmusrb_pkg;
	`include "pmusrb_params.svh"

	// serial frame phases
	typedef enum logic [1:0] {
		PH_CMD,
		PH_ADDR,
		PH_DATA,
		PH_DONE
	} pmusrb_phase_t;

	typedef logic [4:0] pmusrb_addr_t;
	typedef logic [7:0] pmusrb_byte_t;
endpackage

// [hw/pmusrb_top.sv]
// pmusrb_top: serial-accessed register bank of a triple buck plus ldo power unit
// assumes: CLK is the serial clock, free running and sampled on rising edge;
// CS_N, SDI and status inputs are synchronous to CLK; RST_N is the power-on reset
// SDO is a plain registered output with no tristate; the host ignores it outside read data
`timescale 1ns/1ns
`include "pmusrb_params.svh"

module pmusrb_top (
	// clock and reset
	input  wire logic                 CLK,
	input  wire logic                 RST_N,
	// serial port
	input  wire logic                 CS_N,
	input  wire logic                 SDI,
	output logic                      SDO,
	// level select straps
	input  wire logic                 REGULATOR_THREE_LEVEL_SELECT,
	input  wire logic                 REGULATOR_TWO_LEVEL_SELECT,
	// analog status
	input  wire logic                 REGULATOR_THREE_ON_STATUS,
	input  wire logic                 LDO_GOOD,
	input  wire logic [2:0]           REGULATOR_GOOD,
	input  wire logic                 COMPARATOR_OUT,
	// regulator controls
	output pmusrb_pkg::pmusrb_byte_t  REGULATOR_THREE_CODE,
	output pmusrb_pkg::pmusrb_byte_t  REGULATOR_ONE_CODE,
	output pmusrb_pkg::pmusrb_byte_t  REGULATOR_TWO_CODE,
	output pmusrb_pkg::pmusrb_byte_t  REGULATOR_THREE_SLEEP_CODE,
	output logic                      REGULATOR_ONE_FORCED_PWM,
	output logic                      REGULATOR_TWO_FORCED_PWM,
	output logic                      REGULATOR_THREE_FORCED_PWM,
	output logic                      REGULATOR_ONE_ON,
	// comparator controls
	output logic                      COMPARATOR_WIDE_HYST,
	output logic [5:0]                COMPARATOR_THRESHOLD,
	output logic                      COMPARATOR_ON,
	// misc
	output logic                      LDO_EXTRA_SLEEP,
	output logic                      INTERRUPT_OUT
);
	import pmusrb_pkg::*;

	// frame sequencing: two command bits, five address bits, eight data bits;
	// the field counter runs down so that zero always marks a field's last bit
	pmusrb_phase_t phase_q;      // current frame field
	logic [2:0]    cnt_q;        // bits left in field minus one
	logic          cmd_hi_q;     // first command bit
	logic          is_read_q;    // frame is a read
	logic          is_write_q;   // frame is a write
	pmusrb_addr_t  addr_q;       // address shift register
	pmusrb_byte_t  wdata_q;      // write data shift register
	pmusrb_byte_t  rsh_q;        // read data shift register

	// register storage
	// only bits that exist are kept, so unused bits can never stick
	logic [6:0] b3_code_q;       // buck three target
	logic [5:0] b1_code_q;       // buck one target
	logic [5:0] b2_code_q;       // buck two target
	logic [6:0] b3_slp_q;        // buck three deep-sleep target
	logic [2:0] fpwm_q;          // forced pwm, [2]=buck1 [1]=buck2 [0]=buck3
	logic       b1_on_q;         // buck one enable
	logic       hyst_q;          // wide hysteresis
	logic [5:0] thresh_q;        // comparator threshold code
	logic       comp_on_q;       // comparator enable
	logic [4:0] int_mask_q;      // interrupt enables
	logic       ldo_slp_q;       // ldo extra sleep
	logic       int_pol_q;       // interrupt polarity
	logic       strap_pend_q;    // straps still to be latched after reset

	// readback and write strobe
	// the mux looks one bit ahead so read data leaves without a spare cycle
	pmusrb_byte_t rd_mux;        // value of addressed register
	pmusrb_byte_t flags;         // live status view
	pmusrb_addr_t rd_addr;       // address including bit being sampled now
	logic         wr_fire;       // last data bit of a write arrives

	// status is live: no latching, so flags follow the analog side directly
	// bits 7..5 of the status view do not exist and read zero
	// ldo good
	assign flags = {3'h0, LDO_GOOD, REGULATOR_GOOD[2], REGULATOR_GOOD[1],
		REGULATOR_GOOD[0], COMPARATOR_OUT};

	// the last address bit arrives on this edge, so readback uses it directly
	assign rd_addr = {addr_q[3:0], SDI};

	// the mux result only matters on the edge of the last address bit
	// register readback, unmapped and unused bits read zero
	// zero fill
	always_comb begin
		case (rd_addr)
			`PMUSRB_ADDR_B3_CODE:    rd_mux = {1'h0, b3_code_q};
			`PMUSRB_ADDR_B1_CODE:    rd_mux = {2'h0, b1_code_q};
			`PMUSRB_ADDR_B2_CODE:    rd_mux = {2'h0, b2_code_q};
			`PMUSRB_ADDR_B3_SLEEP:   rd_mux = {1'h0, b3_slp_q};
			`PMUSRB_ADDR_REG_CTRL:   rd_mux = {REGULATOR_THREE_ON_STATUS, 2'h0, fpwm_q,
				b1_on_q, 1'h0};
			`PMUSRB_ADDR_COMP_SETUP: rd_mux = {hyst_q, thresh_q, comp_on_q};
			`PMUSRB_ADDR_INT_MASK:   rd_mux = {3'h0, int_mask_q};
			`PMUSRB_ADDR_INT_FLAGS:  rd_mux = flags;
			`PMUSRB_ADDR_MISC:       rd_mux = {6'h0, ldo_slp_q, int_pol_q};
			default:                 rd_mux = 8'h00;
		endcase
	end

	// write commits when the eighth data bit is sampled
	// a frame cut short never reaches this count, so it never writes
	assign wr_fire = !CS_N && (phase_q == PH_DATA) && is_write_q && (cnt_q == 3'h0);

	// frame sequencer: chip select high aborts and rearms
	always_ff @(posedge CLK) begin
		if (!RST_N || CS_N) begin
			// deselect clears every field, so a cut frame leaves nothing behind
			phase_q    <= PH_CMD;
			cnt_q      <= 3'h1;
			cmd_hi_q   <= 1'b0;
			is_read_q  <= 1'b0;
			is_write_q <= 1'b0;
			addr_q     <= 5'h00;
			wdata_q    <= 8'h00;
		end else begin
			case (phase_q)
				PH_CMD: begin
					// first command bit is only remembered
					if (cnt_q == 3'h1) begin
						cmd_hi_q <= SDI;
						cnt_q    <= 3'h0;
					end else begin
						// second bit: decode now, commands 00 and 01 leave both kinds clear
						is_write_q <= ({cmd_hi_q, SDI} == `PMUSRB_CMD_WRITE);
						is_read_q  <= ({cmd_hi_q, SDI} == `PMUSRB_CMD_READ);
						phase_q    <= PH_ADDR;
						cnt_q      <= 3'h4;
					end
				end
				// address msb first
				PH_ADDR: begin
					addr_q <= rd_addr;
					// last address bit: the data phase follows with eight bits
					if (cnt_q == 3'h0) begin
						phase_q <= PH_DATA;
						cnt_q   <= 3'h7;
					end else begin
						cnt_q <= cnt_q - 3'h1;
					end
				end
				// data bits; on a read the input is ignored
				PH_DATA: begin
					// the commit itself happens in the register processes through wr_fire
					wdata_q <= {wdata_q[6:0], SDI};
					if (cnt_q == 3'h0) begin
						phase_q <= PH_DONE;
					end else begin
						cnt_q <= cnt_q - 3'h1;
					end
				end
				// extra clocks past the frame are ignored
				PH_DONE: phase_q <= PH_DONE;
				// no other encoding exists; fall back to waiting for a command
				default: phase_q <= PH_CMD;
			endcase
		end
	end

	// read shifter: loaded with the last address bit, one bit out per clock
	// loading on that edge lets D7 leave at once, hiding the mux in front of it
	// read data out
	always_ff @(posedge CLK) begin
		if (!RST_N || CS_N) begin
			rsh_q <= 8'h00;
		end else if (phase_q == PH_ADDR && cnt_q == 3'h0 && is_read_q) begin
			rsh_q <= rd_mux;
		end else begin
			rsh_q <= {rsh_q[6:0], 1'b0};
		end
	end

	// serial output: bit 6 of shifter on reads, low otherwise
	// D7 comes straight from the mux, D6..D0 from the shifter one edge later
	// output held low
	always_ff @(posedge CLK) begin
		if (!RST_N || CS_N) begin
			SDO <= 1'b0;
		end else if (phase_q == PH_ADDR && cnt_q == 3'h0 && is_read_q) begin
			SDO <= rd_mux[7];
		end else if (phase_q == PH_DATA && is_read_q && cnt_q != 3'h0) begin
			SDO <= rsh_q[6];
		end else begin
			SDO <= 1'b0;
		end
	end

	// reset holds straps pending; they are sampled on the first clock after release,
	// so the codes follow the pins as they stand once reset lets go; a frame cannot
	// start before that edge, so no write can race the strap load
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			strap_pend_q <= 1'b1;
		end else begin
			strap_pend_q <= 1'b0;
		end
	end

	// voltage code registers
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			b3_code_q <= `PMUSRB_RST_B3_SEL_LO;
			b1_code_q <= `PMUSRB_RST_B1_CODE;
			b2_code_q <= `PMUSRB_RST_B2_SEL_LO;
			b3_slp_q  <= `PMUSRB_RST_SLP_SEL_LO;
		end else if (strap_pend_q) begin
			// straps take priority over anything else on this edge
			// buck three strap
			b3_code_q <= REGULATOR_THREE_LEVEL_SELECT ? `PMUSRB_RST_B3_SEL_HI
				: `PMUSRB_RST_B3_SEL_LO;
			b2_code_q <= REGULATOR_TWO_LEVEL_SELECT ? `PMUSRB_RST_B2_SEL_HI
				: `PMUSRB_RST_B2_SEL_LO;
			b3_slp_q  <= REGULATOR_THREE_LEVEL_SELECT ? `PMUSRB_RST_SLP_SEL_HI
				: `PMUSRB_RST_SLP_SEL_LO;
		end else if (wr_fire) begin
			// byte is seven shifted bits plus the bit on the wire now
			case (addr_q)
				`PMUSRB_ADDR_B3_CODE:  b3_code_q <= {wdata_q[5:0], SDI};
				`PMUSRB_ADDR_B1_CODE:  b1_code_q <= {wdata_q[4:0], SDI};
				`PMUSRB_ADDR_B2_CODE:  b2_code_q <= {wdata_q[4:0], SDI};
				`PMUSRB_ADDR_B3_SLEEP: b3_slp_q  <= {wdata_q[5:0], SDI};
				default: ;
			endcase
		end
	end

	// control, comparator, mask and misc registers
	// writes to fields that do not exist simply find no flip-flop to land in
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			fpwm_q     <= 3'h0;
			b1_on_q    <= 1'b1;
			hyst_q     <= 1'b0;
			thresh_q   <= `PMUSRB_RST_THRESH;
			comp_on_q  <= 1'b1;
			int_mask_q <= `PMUSRB_RST_INT_MASK;
			ldo_slp_q  <= 1'b0;
			int_pol_q  <= 1'b0;
		end else if (wr_fire) begin
			case (addr_q)
				`PMUSRB_ADDR_REG_CTRL: begin
					fpwm_q  <= wdata_q[`PMUSRB_BIT_B1_FPWM-1:`PMUSRB_BIT_B3_FPWM-1];
					b1_on_q <= wdata_q[`PMUSRB_BIT_B1_ON-1];
				end
				`PMUSRB_ADDR_COMP_SETUP: begin
					hyst_q    <= wdata_q[`PMUSRB_BIT_HYST-1];
					thresh_q  <= wdata_q[`PMUSRB_THRESH_HI-1:`PMUSRB_THRESH_LO-1];
					comp_on_q <= SDI;
				end
				`PMUSRB_ADDR_INT_MASK: int_mask_q <= {wdata_q[3:0], SDI};
				`PMUSRB_ADDR_MISC: begin
					ldo_slp_q <= wdata_q[`PMUSRB_BIT_LDO_SLEEP-1];
					int_pol_q <= SDI;
				end
				default: ;
			endcase
		end
	end

	// outputs registered from storage
	// one cycle behind storage, so a port never shows a half-shifted byte
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			REGULATOR_THREE_CODE       <= 8'h00;
			REGULATOR_ONE_CODE         <= 8'h00;
			REGULATOR_TWO_CODE         <= 8'h00;
			REGULATOR_THREE_SLEEP_CODE <= 8'h00;
			REGULATOR_ONE_FORCED_PWM   <= 1'b0;
			REGULATOR_TWO_FORCED_PWM   <= 1'b0;
			REGULATOR_THREE_FORCED_PWM <= 1'b0;
			REGULATOR_ONE_ON           <= 1'b0;
			COMPARATOR_WIDE_HYST       <= 1'b0;
			COMPARATOR_THRESHOLD       <= 6'h00;
			COMPARATOR_ON              <= 1'b0;
			LDO_EXTRA_SLEEP            <= 1'b0;
			// inactive at default polarity (active low)
			INTERRUPT_OUT              <= 1'b1;
		end else begin
			REGULATOR_THREE_CODE       <= {1'h0, b3_code_q};
			REGULATOR_ONE_CODE         <= {2'h0, b1_code_q};
			REGULATOR_TWO_CODE         <= {2'h0, b2_code_q};
			REGULATOR_THREE_SLEEP_CODE <= {1'h0, b3_slp_q};
			REGULATOR_ONE_FORCED_PWM   <= fpwm_q[2];
			REGULATOR_TWO_FORCED_PWM   <= fpwm_q[1];
			REGULATOR_THREE_FORCED_PWM <= fpwm_q[0];
			REGULATOR_ONE_ON           <= b1_on_q;
			COMPARATOR_WIDE_HYST       <= hyst_q;
			COMPARATOR_THRESHOLD       <= thresh_q;
			COMPARATOR_ON              <= comp_on_q;
			LDO_EXTRA_SLEEP            <= ldo_slp_q;
			// status is live, so the pin follows the analog side one cycle late
			// masked status
			INTERRUPT_OUT              <= (|(flags[4:0] & int_mask_q)) ~^ int_pol_q;
		end
	end

endmodule // pmusrb_top

// [bench/pmusrb_monitor.sv]
// pmusrb_monitor.sv: port-level checks for the pmu serial register bank
// assumes: bound to pmusrb_top; straps hold steady for at least two clocks after reset release
`timescale 1ns/1ns
module pmusrb_monitor (
	// clock and reset
	input wire logic                     CLK,
	input wire logic                     RST_N,
	// serial port
	input wire logic                     CS_N,
	input wire logic                     SDI,
	input wire logic                     SDO,
	// straps
	input wire logic                     REGULATOR_THREE_LEVEL_SELECT,
	input wire logic                     REGULATOR_TWO_LEVEL_SELECT,
	// controls driven by the bank
	input wire pmusrb_pkg::pmusrb_byte_t REGULATOR_THREE_CODE,
	input wire pmusrb_pkg::pmusrb_byte_t REGULATOR_ONE_CODE,
	input wire pmusrb_pkg::pmusrb_byte_t REGULATOR_TWO_CODE,
	input wire pmusrb_pkg::pmusrb_byte_t REGULATOR_THREE_SLEEP_CODE,
	input wire logic                     REGULATOR_ONE_FORCED_PWM,
	input wire logic                     REGULATOR_ONE_ON,
	input wire logic [5:0]               COMPARATOR_THRESHOLD,
	input wire logic                     COMPARATOR_ON
);
	logic [4:0] cnt_q; // bits sampled in this frame, saturating
	logic [1:0] cmd_q; // the two command bits of this frame

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	// frame bit counter, cleared whenever the frame select is high
	always_ff @(posedge CLK) begin
		if (!RST_N || CS_N) cnt_q <= 5'h00;
		else if (cnt_q != 5'h1F) cnt_q <= cnt_q + 5'h01;
	end

	// command capture from the first two bits only
	always_ff @(posedge CLK) begin
		if (!CS_N && cnt_q < 5'h02) cmd_q <= {cmd_q[0], SDI};
	end

	a_sdo_idle_low: assert property (CS_N [*2] |-> !SDO)
		else $error("serial out not low between frames");
	a_sdo_hdr_low: assert property (!CS_N && cnt_q < 5'h07 |-> !SDO)
		else $error("serial out not low in command or address");
	a_wr_sdo_low: assert property (!CS_N && cnt_q >= 5'h02 && cmd_q == 2'h2 |-> !SDO)
		else $error("serial out not low in write frame");
	a_rd_tail_low: assert property (!CS_N && cnt_q >= 5'h0F && cmd_q == 2'h3 |-> !SDO)
		else $error("serial out active after read data");
	a_b3_reset: assert property ($rose(RST_N) |-> ##2
		(REGULATOR_THREE_CODE == (REGULATOR_THREE_LEVEL_SELECT ? 8'h64 : 8'h3C)
		&& REGULATOR_THREE_SLEEP_CODE == (REGULATOR_THREE_LEVEL_SELECT ? 8'h53 : 8'h0E)))
		else $error("buck three codes wrong after reset");
	a_init_reset: assert property ($rose(RST_N) |-> ##2
		(REGULATOR_ONE_CODE == 8'h26 && REGULATOR_ONE_ON && !REGULATOR_ONE_FORCED_PWM
		&& COMPARATOR_THRESHOLD == 6'h19 && COMPARATOR_ON
		&& (REGULATOR_TWO_LEVEL_SELECT || REGULATOR_TWO_CODE == 8'h0E)))
		else $error("control fields wrong after reset");
	a_codes_stable: assert property (CS_N [*3] ##0 $past(RST_N, 3) |->
		$stable(REGULATOR_THREE_CODE) && $stable(REGULATOR_ONE_CODE)
		&& $stable(REGULATOR_TWO_CODE) && $stable(REGULATOR_THREE_SLEEP_CODE))
		else $error("voltage code moved without a frame");
	a_ctrl_stable: assert property (CS_N [*3] ##0 $past(RST_N, 3) |->
		$stable({REGULATOR_ONE_ON, REGULATOR_ONE_FORCED_PWM, COMPARATOR_THRESHOLD, COMPARATOR_ON}))
		else $error("control moved without a frame");
endmodule // pmusrb_monitor

bind pmusrb_top pmusrb_monitor u_pmusrb_monitor (.CLK(CLK), .RST_N(RST_N), .CS_N(CS_N),
	.SDI(SDI), .SDO(SDO), .REGULATOR_THREE_LEVEL_SELECT(REGULATOR_THREE_LEVEL_SELECT),
	.REGULATOR_TWO_LEVEL_SELECT(REGULATOR_TWO_LEVEL_SELECT),
	.REGULATOR_THREE_CODE(REGULATOR_THREE_CODE), .REGULATOR_ONE_CODE(REGULATOR_ONE_CODE),
	.REGULATOR_TWO_CODE(REGULATOR_TWO_CODE),
	.REGULATOR_THREE_SLEEP_CODE(REGULATOR_THREE_SLEEP_CODE),
	.REGULATOR_ONE_FORCED_PWM(REGULATOR_ONE_FORCED_PWM), .REGULATOR_ONE_ON(REGULATOR_ONE_ON),
	.COMPARATOR_THRESHOLD(COMPARATOR_THRESHOLD), .COMPARATOR_ON(COMPARATOR_ON));

// [bench/pmusrb_spi_master.sv]
// pmusrb_spi_master.sv: behavioural serial host that frames register accesses
// assumes: free running clock; callers wait for one task to end before the next
`timescale 1ns/1ns
module pmusrb_spi_master (
	// clock
	input  wire logic CLK,
	// serial lines
	output logic      CS_N,
	output logic      SDI,
	input  wire logic SDO
);
	// idle: deselected, data line parked
	initial begin
		CS_N = 1'b1;
		SDI  = 1'b0;
	end

	// framing: command, address msb first, data; n may cut or pad the frame
	task automatic xfer(input logic [1:0] cmd, input logic [4:0] a, input logic [7:0] d,
		input int n, output logic [7:0] q);
		logic [16:0] v;
		v = {cmd, a, d, 2'h1};
		q = 8'h00;
		for (int i = 0; i < n; i++) begin
			@(posedge CLK);
			#1;
			// read data shows after the edge that took the last address bit
			if (i >= 7 && i <= 14) q = {q[6:0], SDO};
			CS_N = 1'b0;
			SDI  = v[16 - i];
		end
		@(posedge CLK);
		#1;
		CS_N = 1'b1;
		// released line shows the inverse so a stale bit is never trusted
		SDI  = ~SDI;
	endtask
endmodule // pmusrb_spi_master

// [bench/tb_pmusrb_top.sv]
// tb_pmusrb_top.sv: register bank tests through serial frames
// assumes: pmusrb_spi_master drives the serial side, checker bound to the top
`timescale 1ns/1ns
module tb_pmusrb_top;
	logic       clk, rst_n, cs_n, sdi, sdo, sel3, sel2, on3, ldo_good, cmp_out;
	logic       fp1, fp2, fp3, one_on, hyst, cmp_on, ldo_slp, irq;
	logic [2:0] good;
	logic [5:0] thresh;
	logic [7:0] c3, c1, c2, cs3, q;
	int         fails, samples_checked;
	logic [4:0] ra [11] = '{5'h00, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E,
		5'h01, 5'h1F};
	logic [7:0] rv [11] = '{8'h64, 8'h26, 8'h0E, 8'h53, 8'h82, 8'h33, 8'h01, 8'h14, 8'h00,
		8'h00, 8'h00};
	logic [7:0] wm [9] = '{8'h7F, 8'h3F, 8'h3F, 8'h7F, 8'h1E, 8'hFF, 8'h1F, 8'h00, 8'h03};
	logic [7:0] ro [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h14, 8'h00};
	logic [7:0] dv [3] = '{8'hFF, 8'h5A, 8'h00};

	pmusrb_top u_pmusrb_top (.CLK(clk), .RST_N(rst_n), .CS_N(cs_n), .SDI(sdi), .SDO(sdo),
		.REGULATOR_THREE_LEVEL_SELECT(sel3), .REGULATOR_TWO_LEVEL_SELECT(sel2),
		.REGULATOR_THREE_ON_STATUS(on3), .LDO_GOOD(ldo_good), .REGULATOR_GOOD(good),
		.COMPARATOR_OUT(cmp_out), .REGULATOR_THREE_CODE(c3), .REGULATOR_ONE_CODE(c1),
		.REGULATOR_TWO_CODE(c2), .REGULATOR_THREE_SLEEP_CODE(cs3),
		.REGULATOR_ONE_FORCED_PWM(fp1), .REGULATOR_TWO_FORCED_PWM(fp2),
		.REGULATOR_THREE_FORCED_PWM(fp3), .REGULATOR_ONE_ON(one_on),
		.COMPARATOR_WIDE_HYST(hyst), .COMPARATOR_THRESHOLD(thresh), .COMPARATOR_ON(cmp_on),
		.LDO_EXTRA_SLEEP(ldo_slp), .INTERRUPT_OUT(irq));
	pmusrb_spi_master u_pmusrb_spi_master (.CLK(clk), .CS_N(cs_n), .SDI(sdi), .SDO(sdo));

	// 125 MHz clock
	initial clk = 1'b0;
	always #4 clk = ~clk;

	// compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		u_pmusrb_spi_master.xfer(2'h3, a, 8'h00, 15, q);
		chk(q, exp);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		u_pmusrb_spi_master.xfer(2'h2, a, d, 15, q);
	endtask
	// reset low for three cycles, then two idle edges before any frame
	task automatic rst_pulse;
		@(posedge clk);
		#1;
		rst_n = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b1;
		repeat (2) @(posedge clk);
	endtask
	task print_verdict;
		if (fails == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// a hung frame would otherwise run forever
	initial begin
		#100000;
		fails++;
		print_verdict();
	end

	initial begin
		{rst_n, sel3, sel2, on3, ldo_good, cmp_out, good} = {6'b010110, 3'b010};
		fails = 0;
		samples_checked = 0;
		rst_pulse();
		for (int i = 0; i < 11; i++) rd(ra[i], rv[i]);
		// each pattern written everywhere, read back, then seen on the ports
		for (int k = 0; k < 3; k++) begin
			for (int i = 0; i < 9; i++) wr(ra[i], dv[k]);
			for (int i = 0; i < 9; i++) rd(ra[i], (dv[k] & wm[i]) | ro[i]);
			repeat (2) @(posedge clk);
			#1;
			chk(c3, {1'b0, dv[k][6:0]});
			chk(cs3, {1'b0, dv[k][6:0]});
			chk(c1, {2'b00, dv[k][5:0]});
			chk(c2, {2'b00, dv[k][5:0]});
			chk({4'h0, fp1, fp2, fp3, one_on}, {4'h0, dv[k][4:1]});
			chk({hyst, thresh, cmp_on}, dv[k]);
			chk({6'h00, ldo_slp, irq}, {6'h00, dv[k][1], dv[k][0] ~^ (|(dv[k][4:0] & 5'h14))});
		end
		// comparator as the only enabled source, active high output
		wr(5'h0C, 8'h01);
		wr(5'h0E, 8'h01);
		cmp_out = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk({7'h00, irq}, 8'h01);
		rd(5'h0D, 8'h15);
		cmp_out = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk({7'h00, irq}, 8'h00);
		// bad commands and a short write leave the register alone
		u_pmusrb_spi_master.xfer(2'h1, 5'h07, 8'h11, 15, q);
		u_pmusrb_spi_master.xfer(2'h0, 5'h07, 8'h11, 15, q);
		u_pmusrb_spi_master.xfer(2'h2, 5'h07, 8'h11, 10, q);
		u_pmusrb_spi_master.xfer(2'h3, 5'h07, 8'h00, 17, q);
		chk(q, 8'h00);
		// second reset with the buck three strap low and the buck two strap high
		sel3 = 1'b0;
		sel2 = 1'b1;
		rst_pulse();
		rd(5'h00, 8'h3C);
		rd(5'h09, 8'h0E);
		rd(5'h08, 8'h26);
		print_verdict();
	end
endmodule // tb_pmusrb_top
